// ---- include/pxs_defines.vh ----
`ifndef PXS_DEFINES_VH
`define PXS_DEFINES_VH
// ----------------------------------------
// Bus addresses and register pointers
// ----------------------------------------
`define PXS_ADDR_NORM  7'h39
`define PXS_ADDR_ALT   7'h38
`define PXS_P_ENABLE   8'h80
`define PXS_P_PCOUNT   8'h81
`define PXS_P_PLEN     8'h82
`define PXS_P_OFFSET   8'h83
`define PXS_P_RESL     8'h84
`define PXS_P_RESH     8'h85
// ----------------------------------------
// Enable byte fields and reset values
// ----------------------------------------
`define PXS_B_PON      0
`define PXS_B_PEN      2
`define PXS_B_SAI      6
`define PXS_RST_EN     8'h00
`define PXS_RST_PCNT   8'h08
`define PXS_RST_PLEN   8'h08
`define PXS_RST_OFF    8'h00
// ----------------------------------------
// AXI4-Lite map
// ----------------------------------------
`define PXS_A_CTRL     4'h0
`define PXS_A_STAT     4'h4
`define PXS_A_RES      4'h8
`define PXS_RESP_OK    2'h0
`define PXS_RESP_ERR   2'h2
// ----------------------------------------
// Timing
// ----------------------------------------
`define PXS_CLK_MHZ    100
`define PXS_T_WAKE_US  100
`define PXS_T_RDY_US   1500
`define PXS_T_FIX_CUS  7875
`define PXS_T_LOCK_US  20
`define PXS_LEN_MUL    7
`define PXS_PUL_MUL    2
`define PXS_PUL_ADD    22
`endif

// ---- rtl/pxs_top.v ----
// Contract
// - Answer as slave at 0x39 with normal pin wiring.
// - Work at standard and fast bus clock rates.
// - An 8-bit pointer selects the byte read or written.
// - Pointer advances by one after every data byte.
// - Pointer survives STOP and idle, never cleared.
// - Back-to-back reads may skip the pointer byte.
// - Swapped pins give alternate address 0x38.
// - Device NACKs that first dummy access.
// - Device drives ACK or NACK on ninth clock of writes.
// - Short read after a read fetches from kept pointer.
// - Power-on plus enable wakes to active after 100 us.
// - Commands accepted 1.5 ms after power-up.
// - Integration is 7L + N(2L + 22 us) + 78.75 us.
// - Power-on set, not integrating, means idle.
// - Power-on clear and bus idle means sleep; SLEEP_AFTER_INTERRUPT keeps it.
// - Each measurement yields a 14-bit result.
// - Crosstalk offset is subtracted from the signal.
// - Power-on bit starts oscillator and converter.
// - Proximity enable bit runs detection cycles.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`include "pxs_defines.vh"
module pxs_top #(
	parameter WAKE_CYC = `PXS_T_WAKE_US * `PXS_CLK_MHZ,
	parameter RDY_CYC  = `PXS_T_RDY_US * `PXS_CLK_MHZ,
	parameter FIX_CYC  = `PXS_T_FIX_CUS * `PXS_CLK_MHZ / 100,
	parameter US_CYC   = `PXS_CLK_MHZ
) (
	input  wire        MCLK,
	input  wire        RST_B,
	input  wire        PIN_A_I,
	output wire        PIN_A_O,
	output wire        PIN_A_OE,
	input  wire        PIN_B_I,
	output wire        PIN_B_O,
	output wire        PIN_B_OE,
	input  wire [13:0] PD_ACCUM,
	output wire        OSC_EN,
	output wire        MEAS_ACTIVE,
	input  wire [3:0]  S_AXI_AWADDR,
	input  wire        S_AXI_AWVALID,
	output wire        S_AXI_AWREADY,
	input  wire [31:0] S_AXI_WDATA,
	input  wire [3:0]  S_AXI_WSTRB,
	input  wire        S_AXI_WVALID,
	output wire        S_AXI_WREADY,
	output wire [1:0]  S_AXI_BRESP,
	output wire        S_AXI_BVALID,
	input  wire        S_AXI_BREADY,
	input  wire [3:0]  S_AXI_ARADDR,
	input  wire        S_AXI_ARVALID,
	output wire        S_AXI_ARREADY,
	output wire [31:0] S_AXI_RDATA,
	output wire [1:0]  S_AXI_RRESP,
	output wire        S_AXI_RVALID,
	input  wire        S_AXI_RREADY
);
	localparam I_IDLE = 4'h0, I_ADDR = 4'h1, I_AACK = 4'h2, I_REG = 4'h3;
	localparam I_RACK = 4'h4, I_WDAT = 4'h5, I_WACK = 4'h6;
	localparam I_RDAT = 4'h7, I_MACK = 4'h8;
	localparam P_SLEEP = 2'h0, P_WAKE = 2'h1, P_IDLE = 2'h2, P_ACT = 2'h3;
	localparam LOCK_CYC = `PXS_T_LOCK_US * `PXS_CLK_MHZ;

	reg [1:0]  sy1_reg, sy2_reg, prv_reg;
	reg        init_reg, swap_reg, last_reg, ready_reg;
	reg [11:0] lock_reg;
	reg [17:0] rdy_reg;
	reg [3:0]  ist_reg, bit_reg;
	reg [7:0]  sh_reg, ptr_reg;
	reg        rw_reg, drv_reg, busy_reg;
	reg        iwe_reg;
	reg [7:0]  iwa_reg, iwd_reg;
	reg [7:0]  en_reg, pcnt_reg, plen_reg, off_reg;
	reg        sai_hold_reg;
	reg [1:0]  pst_reg;
	reg [23:0] tmr_reg;
	reg [13:0] res_reg;
	reg        awh_reg, wh_reg, bv_reg, rv_reg;
	reg [3:0]  awa_reg, wst_reg;
	reg [31:0] wd_reg, rd_reg;
	reg [1:0]  br_reg, rr_reg;

	// ----------------------------------------
	// Pin sampling and address selection
	// ----------------------------------------
	wire scl  = swap_reg ? sy2_reg[1] : sy2_reg[0];
	wire sda  = swap_reg ? sy2_reg[0] : sy2_reg[1];
	wire pscl = swap_reg ? prv_reg[1] : prv_reg[0];
	wire psda = swap_reg ? prv_reg[0] : prv_reg[1];
	wire sc_r = scl & ~pscl;
	wire sc_f = ~scl & pscl;
	wire start = init_reg & scl & pscl & psda & ~sda;
	wire stop  = init_reg & scl & pscl & ~psda & sda;
	wire [6:0] my_addr = swap_reg ? `PXS_ADDR_ALT : `PXS_ADDR_NORM;
	wire power_on_bit = en_reg[`PXS_B_PON];
	wire proximity_enable_bit = en_reg[`PXS_B_PEN];
	wire sleep_after_interrupt = en_reg[`PXS_B_SAI];

	always @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			sy1_reg  <= 2'h3;
			sy2_reg  <= 2'h3;
			prv_reg  <= 2'h3;
			init_reg <= 1'b0;
			swap_reg <= 1'b0;
			last_reg <= 1'b0;
			lock_reg <= 12'h000;
			rdy_reg  <= 18'h00000;
			ready_reg <= 1'b0;
		end else begin
			sy1_reg <= {PIN_B_I, PIN_A_I};
			sy2_reg <= sy1_reg;
			prv_reg <= sy2_reg;
			if (rdy_reg == RDY_CYC[17:0])
				ready_reg <= 1'b1;
			else
				rdy_reg <= rdy_reg + 18'h00001;
			// The pin that rose last before a long idle is data
			if (!init_reg) begin
				if (sy2_reg != 2'h3)
					lock_reg <= 12'h000;
				else if (prv_reg != 2'h3) begin
					last_reg <= ~prv_reg[0];
					lock_reg <= 12'h001;
				end else if (lock_reg == LOCK_CYC[11:0]) begin
					init_reg <= 1'b1;
					swap_reg <= last_reg;
				end else if (lock_reg != 12'h000)
					lock_reg <= lock_reg + 12'h001;
			end
		end
	end

	// ----------------------------------------
	// Register byte decode
	// ----------------------------------------
	function [7:0] rd_byte;
		input [7:0] a;
		begin
			case (a)
			`PXS_P_ENABLE: rd_byte = en_reg;
			`PXS_P_PCOUNT: rd_byte = pcnt_reg;
			`PXS_P_PLEN:   rd_byte = plen_reg;
			`PXS_P_OFFSET: rd_byte = off_reg;
			`PXS_P_RESL:   rd_byte = res_reg[7:0];
			`PXS_P_RESH:   rd_byte = {2'b00, res_reg[13:8]};
			default:       rd_byte = 8'h00;
			endcase
		end
	endfunction
	wire [7:0] rb = rd_byte(ptr_reg);

	// ----------------------------------------
	// Serial slave engine
	// ----------------------------------------
	always @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			ist_reg <= I_IDLE;
			bit_reg <= 4'h0;
			sh_reg  <= 8'h00;
			ptr_reg <= 8'h00;
			rw_reg  <= 1'b0;
			drv_reg <= 1'b0;
			busy_reg <= 1'b0;
			iwe_reg <= 1'b0;
			iwa_reg <= 8'h00;
			iwd_reg <= 8'h00;
		end else begin
			iwe_reg <= 1'b0;
			if (start) begin
				ist_reg <= I_ADDR;
				bit_reg <= 4'h0;
				drv_reg <= 1'b0;
				busy_reg <= 1'b1;
			end else if (stop) begin
				ist_reg <= I_IDLE;
				drv_reg <= 1'b0;
				busy_reg <= 1'b0;
			end else if (sc_r) begin
				case (ist_reg)
				I_ADDR, I_REG, I_WDAT: begin
					sh_reg  <= {sh_reg[6:0], sda};
					bit_reg <= bit_reg + 4'h1;
				end
				I_MACK: begin
					ptr_reg <= ptr_reg + 8'h01;
					if (sda)
						ist_reg <= I_IDLE;
				end
				default: ;
				endcase
			end else if (sc_f) begin
				case (ist_reg)
				I_ADDR: if (bit_reg == 4'h8) begin
					bit_reg <= 4'h0;
					if (sh_reg[7:1] == my_addr && ready_reg) begin
						rw_reg  <= sh_reg[0];
						drv_reg <= 1'b1;
						ist_reg <= I_AACK;
					end else
						ist_reg <= I_IDLE;
				end
				I_AACK: if (rw_reg) begin
					ist_reg <= I_RDAT;
					sh_reg  <= rb;
					drv_reg <= ~rb[7];
					bit_reg <= 4'h0;
				end else begin
					drv_reg <= 1'b0;
					ist_reg <= I_REG;
				end
				I_REG: if (bit_reg == 4'h8) begin
					bit_reg <= 4'h0;
					ptr_reg <= sh_reg;
					drv_reg <= 1'b1;
					ist_reg <= I_RACK;
				end
				I_WDAT: if (bit_reg == 4'h8) begin
					bit_reg <= 4'h0;
					iwe_reg <= 1'b1;
					iwa_reg <= ptr_reg;
					iwd_reg <= sh_reg;
					ptr_reg <= ptr_reg + 8'h01;
					drv_reg <= 1'b1;
					ist_reg <= I_WACK;
				end
				I_RACK, I_WACK: begin
					drv_reg <= 1'b0;
					ist_reg <= I_WDAT;
				end
				I_RDAT: if (bit_reg == 4'h7) begin
					drv_reg <= 1'b0;
					ist_reg <= I_MACK;
				end else begin
					bit_reg <= bit_reg + 4'h1;
					drv_reg <= ~sh_reg[6];
					sh_reg  <= {sh_reg[6:0], 1'b0};
				end
				I_MACK: begin
					ist_reg <= I_RDAT;
					sh_reg  <= rb;
					drv_reg <= ~rb[7];
					bit_reg <= 4'h0;
				end
				default: ;
				endcase
			end
		end
	end

	// Only the data pin is ever pulled low
	assign PIN_A_O  = 1'b0;
	assign PIN_B_O  = 1'b0;
	assign PIN_A_OE = drv_reg & swap_reg;
	assign PIN_B_OE = drv_reg & ~swap_reg;

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	wire axi_we = awh_reg & wh_reg & ~bv_reg;
	wire ctl_we = axi_we && awa_reg == `PXS_A_CTRL;
	wire en_wr  = (iwe_reg && iwa_reg == `PXS_P_ENABLE) ||
		(ctl_we && wst_reg[0]);

	always @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			en_reg   <= `PXS_RST_EN;
			pcnt_reg <= `PXS_RST_PCNT;
			plen_reg <= `PXS_RST_PLEN;
			off_reg  <= `PXS_RST_OFF;
		end else if (iwe_reg) begin
			case (iwa_reg)
			`PXS_P_ENABLE: en_reg   <= iwd_reg;
			`PXS_P_PCOUNT: pcnt_reg <= iwd_reg;
			`PXS_P_PLEN:   plen_reg <= iwd_reg;
			`PXS_P_OFFSET: off_reg  <= iwd_reg;
			default: ;
			endcase
		end else if (ctl_we) begin
			if (wst_reg[0])
				en_reg <= wd_reg[7:0];
			if (wst_reg[1])
				pcnt_reg <= wd_reg[15:8];
			if (wst_reg[2])
				plen_reg <= wd_reg[23:16];
			if (wst_reg[3])
				off_reg <= wd_reg[31:24];
		end
	end

	// ----------------------------------------
	// Power states and measurement
	// ----------------------------------------
	wire [31:0] us_sum = `PXS_LEN_MUL * plen_reg + pcnt_reg *
		(`PXS_PUL_MUL * plen_reg + `PXS_PUL_ADD);
	wire [31:0] int_cyc = us_sum * US_CYC + FIX_CYC;
	wire signed [15:0] diff = $signed({2'b00, PD_ACCUM}) -
		$signed({{8{off_reg[7]}}, off_reg});

	always @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			pst_reg <= P_SLEEP;
			tmr_reg <= 24'h000000;
			res_reg <= 14'h0000;
			sai_hold_reg <= 1'b0;
		end else begin
			if (en_wr)
				sai_hold_reg <= 1'b0;
			if (!power_on_bit && !busy_reg)
				pst_reg <= P_SLEEP;
			else case (pst_reg)
			P_SLEEP: if (power_on_bit && !sai_hold_reg && !en_wr) begin
				pst_reg <= proximity_enable_bit ? P_WAKE : P_IDLE;
				tmr_reg <= WAKE_CYC[23:0];
			end
			P_WAKE: if (tmr_reg == 24'h000000) begin
				pst_reg <= P_ACT;
				tmr_reg <= int_cyc[23:0];
			end else
				tmr_reg <= tmr_reg - 24'h000001;
			P_IDLE: if (proximity_enable_bit && power_on_bit) begin
				pst_reg <= P_ACT;
				tmr_reg <= int_cyc[23:0];
			end
			P_ACT: if (tmr_reg == 24'h000000) begin
				if (diff[15])
					res_reg <= 14'h0000;
				else if (diff[14])
					res_reg <= 14'h3FFF;
				else
					res_reg <= diff[13:0];
				if (sleep_after_interrupt && !en_wr) begin
					pst_reg <= P_SLEEP;
					sai_hold_reg <= 1'b1;
				end else
					pst_reg <= P_IDLE;
			end else
				tmr_reg <= tmr_reg - 24'h000001;
			default: pst_reg <= P_SLEEP;
			endcase
		end
	end

	assign OSC_EN = pst_reg != P_SLEEP;
	assign MEAS_ACTIVE = pst_reg == P_ACT;

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	always @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			awh_reg <= 1'b0;
			wh_reg  <= 1'b0;
			bv_reg  <= 1'b0;
			rv_reg  <= 1'b0;
			awa_reg <= 4'h0;
			wst_reg <= 4'h0;
			wd_reg  <= 32'h00000000;
			rd_reg  <= 32'h00000000;
			br_reg  <= `PXS_RESP_OK;
			rr_reg  <= `PXS_RESP_OK;
		end else begin
			if (S_AXI_AWVALID && !awh_reg) begin
				awh_reg <= 1'b1;
				awa_reg <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && !wh_reg) begin
				wh_reg  <= 1'b1;
				wd_reg  <= S_AXI_WDATA;
				wst_reg <= S_AXI_WSTRB;
			end
			if (axi_we) begin
				bv_reg <= 1'b1;
				br_reg <= (awa_reg == `PXS_A_CTRL) ?
					`PXS_RESP_OK : `PXS_RESP_ERR;
			end
			if (bv_reg && S_AXI_BREADY) begin
				bv_reg  <= 1'b0;
				awh_reg <= 1'b0;
				wh_reg  <= 1'b0;
			end
			if (S_AXI_ARVALID && !rv_reg) begin
				rv_reg <= 1'b1;
				rr_reg <= `PXS_RESP_OK;
				case (S_AXI_ARADDR)
				`PXS_A_CTRL: rd_reg <= {off_reg, plen_reg, pcnt_reg, en_reg};
				`PXS_A_STAT: rd_reg <= {16'h0000, ptr_reg, ready_reg,
					init_reg, swap_reg, busy_reg, sai_hold_reg, 1'b0,
					pst_reg};
				`PXS_A_RES:  rd_reg <= {18'h00000, res_reg};
				default: begin
					rd_reg <= 32'h00000000;
					rr_reg <= `PXS_RESP_ERR;
				end
				endcase
			end else if (rv_reg && S_AXI_RREADY)
				rv_reg <= 1'b0;
		end
	end

	assign S_AXI_AWREADY = ~awh_reg;
	assign S_AXI_WREADY  = ~wh_reg;
	assign S_AXI_BVALID  = bv_reg;
	assign S_AXI_BRESP   = br_reg;
	assign S_AXI_ARREADY = ~rv_reg;
	assign S_AXI_RVALID  = rv_reg;
	assign S_AXI_RDATA   = rd_reg;
	assign S_AXI_RRESP   = rr_reg;
endmodule // pxs_top

// ---- dv/pxs_host.sv ----
module pxs_host (
	input  wire  clk,
	input  wire  sda,
	output logic scl_oe,
	output logic sda_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	// --------------------
	// Bus master model
	// --------------------
	initial begin
		scl_oe = 1'b0;
		sda_oe = 1'b0;
	end
	task automatic hold();
		repeat (8) @(posedge clk);
	endtask
	task automatic xs();
		sda_oe <= 1'b0;
		hold();
		scl_oe <= 1'b0;
		hold();
		sda_oe <= 1'b1;
		hold();
		scl_oe <= 1'b1;
		hold();
	endtask
	task automatic xp();
		sda_oe <= 1'b1;
		hold();
		scl_oe <= 1'b0;
		hold();
		sda_oe <= 1'b0;
		hold();
	endtask
	task automatic xb(input logic [7:0] d, input logic m,
		output logic [7:0] q, output logic a);
		for (int i = 8; i >= 0; i--) begin
			sda_oe <= (i > 0) ? !d[i-1] : !m;
			hold();
			scl_oe <= 1'b0;
			hold();
			if (i > 0) q[i-1] = sda;
			else a = sda;
			scl_oe <= 1'b1;
			hold();
		end
	endtask
endmodule // pxs_host

// ---- dv/pxs_checker.sv ----
module pxs_checker (
	input logic        MCLK,
	input logic        RST_B,
	input logic        PIN_A_I,
	input logic        PIN_A_O,
	input logic        PIN_A_OE,
	input logic        PIN_B_I,
	input logic        PIN_B_O,
	input logic        PIN_B_OE,
	input logic        OSC_EN,
	input logic        MEAS_ACTIVE,
	input logic        S_AXI_AWVALID,
	input logic        S_AXI_AWREADY,
	input logic        S_AXI_WVALID,
	input logic        S_AXI_WREADY,
	input logic        S_AXI_BVALID,
	input logic        S_AXI_BREADY,
	input logic        S_AXI_ARVALID,
	input logic        S_AXI_ARREADY,
	input logic [31:0] S_AXI_RDATA,
	input logic        S_AXI_RVALID,
	input logic        S_AXI_RREADY
);
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RST_B);
	sequence s_wtake;
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
	endsequence
	property p_bresp;
		s_wtake |-> ##[1:2] S_AXI_BVALID;
	endproperty
	a_bresp: assert property (p_bresp) else $error("late write reply");
	property p_bhold;
		S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID;
	endproperty
	a_bhold: assert property (p_bhold) else $error("write reply lost");
	property p_rd;
		S_AXI_ARVALID && S_AXI_ARREADY |-> ##[1:2] S_AXI_RVALID;
	endproperty
	a_rd: assert property (p_rd) else $error("late read reply");
	property p_rhold;
		S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read reply moved");
	property p_ardy;
		S_AXI_RVALID |-> !S_AXI_ARREADY;
	endproperty
	a_ardy: assert property (p_ardy) else $error("read taken early");
	property p_osc;
		MEAS_ACTIVE |-> OSC_EN;
	endproperty
	a_osc: assert property (p_osc) else $error("active without osc");
	property p_pins;
		!PIN_A_O && !PIN_B_O;
	endproperty
	a_pins: assert property (p_pins) else $error("pad driven high");
	property p_oe;
		($changed(PIN_B_OE) |-> !PIN_A_I) and
			($changed(PIN_A_OE) |-> !PIN_B_I);
	endproperty
	a_oe: assert property (p_oe) else $error("sda moved early");
	property p_integ;
		$rose(MEAS_ACTIVE) |-> MEAS_ACTIVE [*8];
	endproperty
	a_integ: assert property (p_integ) else $error("short active");
	property p_wake;
		$rose(OSC_EN) |-> !MEAS_ACTIVE [*8];
	endproperty
	a_wake: assert property (p_wake) else $error("no wake delay");
endmodule // pxs_checker

// ---- dv/tb_prox_sensor_i2c_slave_access.sv ----
`include "pxs_defines.vh"
module tb_prox_sensor_i2c_slave_access;
	timeunit 1ns;
	timeprecision 1ns;
	logic        MCLK = 1'b0;
	logic        RST_B = 1'b0;
	logic [13:0] PD_ACCUM = 14'h0000;
	logic [3:0]  S_AXI_AWADDR = 4'h0;
	logic [3:0]  S_AXI_ARADDR = 4'h0;
	logic [31:0] S_AXI_WDATA = 32'h0;
	logic        S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0;
	logic        S_AXI_BREADY = 1'b0, S_AXI_ARVALID = 1'b0;
	logic        S_AXI_RREADY = 1'b0;
	logic        PIN_A_O, PIN_A_OE, PIN_B_O, PIN_B_OE, OSC_EN;
	logic        MEAS_ACTIVE, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
	logic        S_AXI_ARREADY, S_AXI_RVALID, scl_oe, sda_oe, k;
	logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, rr;
	logic [31:0] S_AXI_RDATA, rd;
	logic [7:0]  q;
	int          failures = 0, n_checks = 0, cyc = 0, cnt;
	wire         pad_a = !(PIN_A_OE || scl_oe);
	wire         pad_b = !(PIN_B_OE || sda_oe);
	pxs_host h (.clk(MCLK), .sda(pad_b), .scl_oe(scl_oe), .sda_oe(sda_oe));
	pxs_top #(.WAKE_CYC(20), .RDY_CYC(50), .FIX_CYC(5), .US_CYC(1)) dut (
		.MCLK(MCLK), .RST_B(RST_B), .PIN_A_I(pad_a), .PIN_A_O(PIN_A_O),
		.PIN_A_OE(PIN_A_OE), .PIN_B_I(pad_b), .PIN_B_O(PIN_B_O),
		.PIN_B_OE(PIN_B_OE), .PD_ACCUM(PD_ACCUM), .OSC_EN(OSC_EN),
		.MEAS_ACTIVE(MEAS_ACTIVE), .S_AXI_AWADDR(S_AXI_AWADDR),
		.S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
		.S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(4'hF),
		.S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
		.S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
		.S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
		.S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
		.S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
		.S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY));
	// --------------------
	// Shared tasks
	// --------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic print_verdict();
		$display("checks=%0d failures=%0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic axw(input logic [3:0] a, input logic [31:0] d,
		input logic [1:0] e);
		@(posedge MCLK);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= d;
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WVALID <= 1'b1;
		S_AXI_BREADY <= 1'b1;
		do begin
			@(posedge MCLK);
			if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
			if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
		end while (!S_AXI_BVALID);
		chk(S_AXI_BRESP, e);
		S_AXI_BREADY <= 1'b0;
	endtask
	task automatic axr(input logic [3:0] a);
		@(posedge MCLK);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'b1;
		S_AXI_RREADY <= 1'b1;
		do begin
			@(posedge MCLK);
			if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
		end while (!S_AXI_RVALID);
		rd = S_AXI_RDATA;
		rr = S_AXI_RRESP;
		S_AXI_RREADY <= 1'b0;
	endtask
	task automatic hw(input logic [7:0] d, input logic e);
		h.xb(d, 1'b1, q, k);
		chk(k, e);
	endtask
	task automatic hr(input logic m, input logic [7:0] e);
		h.xb(8'hFF, m, q, k);
		chk(q, e);
	endtask
	// --------------------
	// Clock, timeout, tests
	// --------------------
	always #5 MCLK = ~MCLK;
	always @(posedge MCLK) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			failures++;
			print_verdict();
		end
	end
	initial begin
		repeat (10) @(posedge MCLK);
		RST_B <= 1'b1;
		axr(`PXS_A_CTRL);
		chk(rd, 32'h00080800);
		axr(`PXS_A_STAT);
		chk(rd, 32'h00000000);
		h.xs();
		hw(8'h72, 1'b1);
		h.xp();
		repeat (2100) @(posedge MCLK);
		$display("test dummy done");
		h.xs();
		hw(8'h72, 1'b0);
		hw(8'h81, 1'b0);
		hw(8'h05, 1'b0);
		hw(8'h07, 1'b0);
		h.xp();
		axr(`PXS_A_CTRL);
		chk(rd, 32'h00070500);
		axw(`PXS_A_CTRL, 32'h03070500, `PXS_RESP_OK);
		h.xs();
		hw(8'h70, 1'b1);
		h.xp();
		$display("test write done");
		h.xs();
		hw(8'h72, 1'b0);
		hw(8'h81, 1'b0);
		h.xs();
		hw(8'h73, 1'b0);
		hr(1'b0, 8'h05);
		hr(1'b1, 8'h07);
		h.xp();
		h.xs();
		hw(8'h73, 1'b0);
		hr(1'b1, 8'h03);
		h.xp();
		axr(`PXS_A_STAT);
		chk(rd[15:5], {8'h84, 3'b110});
		$display("test read done");
		axr(4'hC);
		chk(rr, `PXS_RESP_ERR);
		chk(rd, 32'h00000000);
		axw(4'hC, 32'h0, `PXS_RESP_ERR);
		$display("test map done");
		PD_ACCUM <= 14'h0100;
		h.xs();
		hw(8'h72, 1'b0);
		hw(8'h80, 1'b0);
		hw(8'h05, 1'b0);
		h.xp();
		while (!MEAS_ACTIVE) @(negedge MCLK);
		while (MEAS_ACTIVE) @(negedge MCLK);
		axr(`PXS_A_RES);
		chk(rd, 32'h000000FD);
		chk(OSC_EN, 1'b1);
		h.xs();
		hw(8'h72, 1'b0);
		hw(8'h84, 1'b0);
		h.xs();
		hw(8'h73, 1'b0);
		hr(1'b0, 8'hFD);
		hr(1'b1, 8'h00);
		h.xp();
		while (MEAS_ACTIVE) @(negedge MCLK);
		while (!MEAS_ACTIVE) @(negedge MCLK);
		cnt = 0;
		while (MEAS_ACTIVE) begin
			@(negedge MCLK);
			cnt++;
		end
		chk(cnt, 32'h000000EB);
		while (!MEAS_ACTIVE) @(negedge MCLK);
		repeat (20) @(posedge MCLK);
		axw(`PXS_A_CTRL, 32'h03070500, `PXS_RESP_OK);
		repeat (4) @(posedge MCLK);
		axr(`PXS_A_STAT);
		chk({OSC_EN, rd[1:0]}, 3'b000);
		axw(`PXS_A_CTRL, 32'h03070545, `PXS_RESP_OK);
		while (!MEAS_ACTIVE) @(negedge MCLK);
		while (MEAS_ACTIVE) @(negedge MCLK);
		repeat (4) @(posedge MCLK);
		axr(`PXS_A_STAT);
		chk({OSC_EN, rd[3], rd[1:0]}, 4'h4);
		axr(`PXS_A_CTRL);
		chk(rd[7:0], 8'h45);
		$display("test power done");
		print_verdict();
	end
endmodule // tb_prox_sensor_i2c_slave_access
bind pxs_top pxs_checker u_chk (.MCLK(MCLK), .RST_B(RST_B),
	.PIN_A_I(PIN_A_I), .PIN_A_O(PIN_A_O), .PIN_A_OE(PIN_A_OE),
	.PIN_B_I(PIN_B_I), .PIN_B_O(PIN_B_O), .PIN_B_OE(PIN_B_OE),
	.OSC_EN(OSC_EN),
	.MEAS_ACTIVE(MEAS_ACTIVE), .S_AXI_AWVALID(S_AXI_AWVALID),
	.S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
	.S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
	.S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
	.S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
	.S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY));
